//--- dv/crcp_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module crcp_asserts #(
	parameter int CHANNELS = 4,
	parameter int EMP_W = 2,
	parameter int CRC_W = 32,
	parameter int CH_W = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic data_valid,
	input wire logic pkt_end,
	input wire logic [EMP_W-1:0] empty_syms,
	input wire logic [CH_W-1:0] data_chan,
	input wire logic chan_init_done,
	input wire logic [CRC_W-1:0] checksum,
	input wire logic crc_bad,
	input wire logic crc_valid,
	input wire logic [CH_W-1:0] crc_chan
);
	// ------------------------------------------------------------------
	// Edges counted since the last reset release
	// ------------------------------------------------------------------
	logic [7:0] rel_cnt_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rel_cnt_q <= 8'h00;
		else if (rel_cnt_q != 8'hFF)
			rel_cnt_q <= rel_cnt_q + 8'h01;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !chan_init_done && !crc_valid)
		else $error("outputs active during reset");
	chk_init_time: assert property (chan_init_done == (rel_cnt_q >= CHANNELS))
		else $error("init done at wrong time");
	chk_valid_after_end: assert property (data_valid && pkt_end && chan_init_done |=> crc_valid)
		else $error("result valid missing after end word");
	chk_valid_cause: assert property (crc_valid |-> $past(data_valid && pkt_end && chan_init_done))
		else $error("result valid without end word");
	chk_result_chan: assert property (crc_valid |-> crc_chan == $past(data_chan))
		else $error("result channel tag wrong");
	chk_sum_stable: assert property (!crc_valid |-> $stable(checksum))
		else $error("checksum moved outside result");
	chk_tag_stable: assert property (!crc_valid |-> $stable(crc_chan))
		else $error("channel tag moved outside result");
	chk_bad_idle: assert property (!crc_bad)
		else $error("bad flag raised in generator");
	chk_empty_zero: assert property (data_valid && !pkt_end |-> empty_syms == '0)
		else $error("empty count nonzero on inner word");
	chk_word_pulse: assert property (data_valid |=> !data_valid)
		else $error("word valid held over two cycles");

	cover property (crc_valid);
	cover property (data_valid && pkt_end && empty_syms != '0);
	cover property ($rose(chan_init_done));
endmodule

`default_nettype wire

//--- dv/crcp_tb.sv
`timescale 1ns/10ps
`default_nettype none

module crcp_tb;
	import crcp_pkg::*;

	logic ref_clk = 1'b0;
	logic rst_n;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	int errors = 0;
	int num_checks = 0;

	crcp_if #(.DATA_W(32), .EMP_W(2), .CRC_W(32), .CH_W(2)) lnk ();

	crcp_engine #(.CHECKER(1'b0)) i_crcp_engine (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk));

	// A checker build and a negated, bit-swapped generator see the same words.
	crcp_if #(.DATA_W(32), .EMP_W(2), .CRC_W(32), .CH_W(2)) lnk_chk ();
	crcp_if #(.DATA_W(32), .EMP_W(2), .CRC_W(32), .CH_W(2)) lnk_neg ();

	assign lnk_chk.data = lnk.data;
	assign lnk_chk.data_valid = lnk.data_valid;
	assign lnk_chk.pkt_start = lnk.pkt_start;
	assign lnk_chk.pkt_end = lnk.pkt_end;
	assign lnk_chk.empty_syms = lnk.empty_syms;
	assign lnk_chk.data_chan = lnk.data_chan;
	assign lnk_neg.data = lnk.data;
	assign lnk_neg.data_valid = lnk.data_valid;
	assign lnk_neg.pkt_start = lnk.pkt_start;
	assign lnk_neg.pkt_end = lnk.pkt_end;
	assign lnk_neg.empty_syms = lnk.empty_syms;
	assign lnk_neg.data_chan = lnk.data_chan;

	crcp_engine #(.CHECKER(1'b1), .NEGATE(1'b1), .BITSWAP(1'b1)) i_crcp_engine_chk (
		.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk_chk));
	crcp_engine #(.CHECKER(1'b0), .NEGATE(1'b1), .BITSWAP(1'b1)) i_crcp_engine_neg (
		.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk_neg));

	crcp_host i_crcp_host (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(lnk));

	crcp_asserts i_crcp_asserts (.ref_clk(ref_clk), .rst_n(rst_n), .data_valid(lnk.data_valid),
		.pkt_end(lnk.pkt_end), .empty_syms(lnk.empty_syms), .data_chan(lnk.data_chan),
		.chan_init_done(lnk.chan_init_done), .checksum(lnk.checksum), .crc_bad(lnk.crc_bad),
		.crc_valid(lnk.crc_valid), .crc_chan(lnk.crc_chan));

	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Bus and checking helpers
	// ------------------------------------------------------------------
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] rd;
		bus(a, 1'b1, wd, rd);
	endtask

	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] rd;
		bus(a, 1'b0, 32'h00000000, rd);
		check32(rd & mask, exp);
		check32({31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask

	task automatic wait_init();
		logic [31:0] rd;
		int n;
		n = 0;
		do
		begin
			bus(OFS_STAT, 1'b0, 32'h00000000, rd);
			n++;
		end
		while (rd[ST_INIT_BIT] !== 1'b1 && n < 20);
		check32(rd & 32'h00000001, 32'h00000001);
	endtask

	// Bitwise remainder, most significant data bit first.
	function automatic logic [31:0] crc_upd(input logic [31:0] s, input logic [31:0] d, input int n);
		logic fb;
		for (int i = 0; i < n; i++)
		begin
			fb = s[31] ^ d[31-i];
			s = {s[30:0], 1'b0};
			if (fb)
				s = s ^ POLY_DEF;
		end
		return s;
	endfunction

	function automatic logic [31:0] rev32(input logic [31:0] v);
		logic [31:0] r;
		for (int i = 0; i < 32; i++)
			r[i] = v[31-i];
		return r;
	endfunction

	function automatic logic [31:0] cmd(input logic sop, input logic eop, input logic [7:0] emp,
		input logic [7:0] ch);
		return {8'h00, ch, emp, 6'h00, eop, sop};
	endfunction

	// Sends one word and, on an end word, checks sum and tag.
	task automatic send(input logic [31:0] w, input logic [31:0] c, input logic [31:0] exp);
		wr(OFS_WORD, w);
		wr(OFS_CMD, c);
		if (c[CMD_EOP_BIT])
		begin
			repeat (3) @(posedge ref_clk);
			rd_chk(OFS_STAT, 32'h00000006, 32'h00000002);
			rd_chk(OFS_SUM, 32'hFFFFFFFF, exp);
			rd_chk(OFS_RCHAN, 32'h000000FF, {24'h000000, c[23:16]});
			check32({31'h0, lnk_chk.crc_bad}, {31'h0, exp != 32'h00000000});
			check32(lnk_chk.checksum, 32'h00000000);
			check32({30'h0, lnk_chk.crc_chan}, {24'h000000, c[23:16]});
			check32(lnk_neg.checksum, rev32(~exp));
			wr(OFS_STAT, 32'h00000002);
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_early_cmd();
		wr(OFS_CMD, cmd(1'b1, 1'b1, 8'h00, 8'h00));
		rd_chk(OFS_STAT, 32'h0000000A, 32'h00000008);
		wait_init();
		wr(OFS_STAT, 32'h0000000A);
		rd_chk(OFS_STAT, 32'h0000000F, 32'h00000001);
	endtask

	task automatic t_regs();
		wr(OFS_WORD, 32'hA5C3F00F);
		rd_chk(OFS_WORD, 32'hFFFFFFFF, 32'hA5C3F00F);
		wr(8'h14, 32'hDEADBEEF);
		rd_chk(8'h14, 32'hFFFFFFFF, 32'h00000000);
	endtask

	task automatic t_single();
		for (int ch = 0; ch < CHANNELS_DEF; ch++)
			send(32'h12345678 + ch, cmd(1'b1, 1'b1, 8'h00, ch[7:0]),
				crc_upd(INIT_DEF, 32'h12345678 + ch, 32));
	endtask

	task automatic t_interleave();
		logic [31:0] s0;
		s0 = crc_upd(INIT_DEF, 32'hCAFEF00D, 32);
		send(32'hCAFEF00D, cmd(1'b1, 1'b0, 8'h00, 8'h00), 32'h0);
		send(32'h0BADF00D, cmd(1'b1, 1'b1, 8'h00, 8'h01), crc_upd(INIT_DEF, 32'h0BADF00D, 32));
		send(32'h9ABCDEF0, cmd(1'b0, 1'b1, 8'h01, 8'h00), crc_upd(s0, 32'h9ABCDEF0, 24));
		send(32'h55AA33CC, cmd(1'b0, 1'b1, 8'h03, 8'h03), crc_upd(INIT_DEF, 32'h55AA33CC, 8));
	endtask

	// A clean codeword leaves a zero remainder; one flipped bit is caught.
	task automatic t_codeword();
		logic [31:0] c1;
		logic [31:0] c2;
		c1 = crc_upd(INIT_DEF, 32'h600DC0DE, 32);
		c2 = c1 ^ 32'h00000100;
		send(32'h600DC0DE, cmd(1'b1, 1'b0, 8'h00, 8'h01), 32'h00000000);
		send(c1, cmd(1'b0, 1'b1, 8'h00, 8'h01), 32'h00000000);
		send(32'h600DC0DE, cmd(1'b1, 1'b0, 8'h00, 8'h01), 32'h00000000);
		send(c2, cmd(1'b0, 1'b1, 8'h00, 8'h01), crc_upd(c1, c2, 32));
	endtask

	task automatic t_reset_again();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd_chk(OFS_STAT, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(OFS_SUM, 32'hFFFFFFFF, 32'h00000000);
		wait_init();
		send(32'h00000001, cmd(1'b1, 1'b1, 8'h00, 8'h02), crc_upd(INIT_DEF, 32'h00000001, 32));
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_early_cmd();
		t_regs();
		t_single();
		t_interleave();
		t_codeword();
		t_reset_again();
		tally_and_finish();
	end

	initial
	begin
		repeat (3000) @(posedge ref_clk);
		errors++;
		tally_and_finish();
	end
endmodule

`default_nettype wire

//--- hdl/crcp_engine.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Active-low reset acts without the clock.
// - Data width is power of two, 1..256.
// - Source asserts valid on each new word.
// - Source marks the first word with start.
// - Source marks the final word with end.
// - Empty count set on end, otherwise zero.
// - Empty count width is log2 of symbols.
// - Generator outputs checksum of polynomial order width.
// - Checker flags bad CRC of previous packet.
// - Result valid when checksum or verdict done.
// - Source drives channel select, log2 channels wide.
// - Init-done asserts when ready for data.
// - Source sends nothing before init-done.
// - Reset restarts init and drops init-done.
// - Result carries the channel tag.
// - One shared port set, one channel per cycle.
// - Load starting value before each packet.
// - Negate complements generator output only.
// - Bit-swap reverses generator checksum bits.
module crcp_engine #(
	parameter int DATA_W = crcp_pkg::DATA_W_DEF,
	parameter int SYMS = crcp_pkg::SYMS_DEF,
	parameter int CRC_W = crcp_pkg::CRC_W_DEF,
	parameter logic [CRC_W-1:0] POLY = crcp_pkg::POLY_DEF[CRC_W-1:0],
	parameter logic [CRC_W-1:0] INIT = crcp_pkg::INIT_DEF[CRC_W-1:0],
	parameter int CHANNELS = crcp_pkg::CHANNELS_DEF,
	parameter bit CHECKER = 1'b0,
	parameter bit NEGATE = 1'b0,
	parameter bit BITSWAP = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	crcp_if.dev lnk
);
	import crcp_pkg::*;

	// ------------------------------------------------------------------
	// Derived sizes
	// ------------------------------------------------------------------
	localparam int SYM_W = DATA_W / SYMS;
	localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam int CNT_W = $clog2(DATA_W + 1) + 1;
	localparam logic [CH_W-1:0] LAST_CH = CH_W'(CHANNELS - 1);

	// Only power-of-two data widths inside the supported span are built.
	localparam bit DATA_W_OK = DATA_W >= DATA_W_MIN && DATA_W <= DATA_W_MAX
		&& (DATA_W & (DATA_W - 1)) == 0;

	if (!DATA_W_OK)
	begin : g_bad_width
		$error("unsupported data width");
	end

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Shifts the first n bits of the word, most significant first, into the remainder.
	function automatic logic [CRC_W-1:0] crc_step(
		input logic [CRC_W-1:0] s,
		input logic [DATA_W-1:0] d,
		input logic [CNT_W-1:0] n
	);
		logic [CRC_W-1:0] r;
		logic fb;
		r = s;
		fb = 1'b0;
		for (int i = 0; i < DATA_W; i++)
		begin
			if (CNT_W'(i) < n)
			begin
				fb = r[CRC_W-1] ^ d[DATA_W-1-i];
				r = {r[CRC_W-2:0], 1'b0};
				if (fb)
				begin
					r = r ^ POLY;
				end
			end
		end
		return r;
	endfunction

	function automatic logic [CRC_W-1:0] bit_rev(input logic [CRC_W-1:0] v);
		logic [CRC_W-1:0] r;
		r = '0;
		for (int i = 0; i < CRC_W; i++)
		begin
			r[i] = v[CRC_W-1-i];
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic {
		ST_INIT,
		ST_RUN
	} crcp_eng_state_t;

	crcp_eng_state_t state_q;
	logic [CH_W-1:0] init_ch_q;
	logic [CRC_W-1:0] crc_q [CHANNELS];
	logic res_valid_q;
	logic [CRC_W-1:0] res_sum_q;
	logic res_bad_q;
	logic [CH_W-1:0] res_chan_q;

	logic take;
	logic [CH_W-1:0] ch;
	logic [CNT_W-1:0] nbits;
	logic [CRC_W-1:0] cur;
	logic [CRC_W-1:0] nxt;
	logic [CRC_W-1:0] gen_out;

	// ------------------------------------------------------------------
	// Word datapath
	// ------------------------------------------------------------------

	// Words presented before init-done are dropped; the source must wait.
	assign take = lnk.data_valid && (state_q == ST_RUN);
	// One channel per cycle: the single select picks the state word.
	assign ch = (lnk.data_chan > LAST_CH) ? LAST_CH : lnk.data_chan;

	always_comb
	begin
		nbits = CNT_W'(DATA_W);
		// Only the empty count on the final word shortens it.
		if (SYMS > 1 && lnk.pkt_end)
		begin
			nbits = CNT_W'(DATA_W) - CNT_W'(lnk.empty_syms) * CNT_W'(SYM_W);
		end
	end

	// A start word always begins from the configured starting value.
	assign cur = lnk.pkt_start ? INIT : crc_q[ch];
	assign nxt = crc_step(cur, lnk.data, nbits);

	always_comb
	begin
		gen_out = NEGATE ? ~nxt : nxt;
		if (BITSWAP)
		begin
			gen_out = bit_rev(gen_out);
		end
	end

	// ------------------------------------------------------------------
	// Initialisation sequencer
	// ------------------------------------------------------------------

	// Reset restarts the walk over all channels.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_INIT;
			init_ch_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_INIT:
				begin
					init_ch_q <= init_ch_q + CH_W'(1);
					if (init_ch_q == LAST_CH)
					begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					state_q <= ST_RUN;
				end
				default:
				begin
					state_q <= ST_INIT;
				end
			endcase
		end
	end

	assign lnk.chan_init_done = (state_q == ST_RUN);

	// ------------------------------------------------------------------
	// Per-channel remainder store
	// ------------------------------------------------------------------

	// The store has no reset; the sequencer writes the start value instead.
	always_ff @(posedge ref_clk)
	begin
		if (state_q == ST_INIT)
		begin
			crc_q[init_ch_q] <= INIT;
		end
		else if (take)
		begin
			// After the final word the channel is rearmed for its next packet.
			crc_q[ch] <= lnk.pkt_end ? INIT : nxt;
		end
	end

	// ------------------------------------------------------------------
	// Result register
	// ------------------------------------------------------------------

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_valid_q <= 1'b0;
		end
		else
		begin
			res_valid_q <= take && lnk.pkt_end;
		end
	end

	// Values only change on a completed packet, so they hold through the pulse.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_sum_q <= '0;
			res_bad_q <= 1'b0;
			res_chan_q <= '0;
		end
		else if (take && lnk.pkt_end)
		begin
			res_chan_q <= ch;
			if (CHECKER)
			begin
				// A clean codeword leaves a zero remainder.
				res_bad_q <= (nxt != '0);
			end
			else
			begin
				res_sum_q <= gen_out;
			end
		end
	end

	assign lnk.crc_valid = res_valid_q;
	assign lnk.checksum = res_sum_q;
	assign lnk.crc_bad = res_bad_q;
	assign lnk.crc_chan = res_chan_q;

endmodule

`default_nettype wire

//--- hdl/crcp_host.sv
`timescale 1ns/10ps
`default_nettype none

module crcp_host #(
	parameter int DATA_W = crcp_pkg::DATA_W_DEF,
	parameter int SYMS = crcp_pkg::SYMS_DEF,
	parameter int CRC_W = crcp_pkg::CRC_W_DEF,
	parameter int CHANNELS = crcp_pkg::CHANNELS_DEF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	crcp_if.src lnk
);
	import crcp_pkg::*;

	localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam int EMP_W = (SYMS > 1) ? $clog2(SYMS) : 1;

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	logic wr_ph_q;
	logic [7:0] addr_q;
	logic [31:0] word_q;
	logic wr_word;
	logic wr_cmd;
	logic wr_stat;

	// Zero wait states: every transfer completes in its first data cycle.
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ph_q <= 1'b0;
			addr_q <= '0;
		end
		else if (hready)
		begin
			wr_ph_q <= hsel && htrans == HTRANS_NONSEQ && hwrite;
			addr_q <= haddr[7:0];
		end
	end

	assign wr_word = wr_ph_q && addr_q == OFS_WORD;
	assign wr_cmd = wr_ph_q && addr_q == OFS_CMD;
	assign wr_stat = wr_ph_q && addr_q == OFS_STAT;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word_q <= '0;
		end
		else if (wr_word)
		begin
			word_q <= hwdata;
		end
	end

	// ------------------------------------------------------------------
	// Word issue
	// ------------------------------------------------------------------
	logic valid_q;
	logic sop_q;
	logic eop_q;
	logic [EMP_W-1:0] emp_q;
	logic [CH_W-1:0] chan_q;
	logic refused_q;
	logic issue;

	// Commands written before init-done are dropped and flagged.
	assign issue = wr_cmd && lnk.chan_init_done;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid_q <= 1'b0;
			sop_q <= 1'b0;
			eop_q <= 1'b0;
			emp_q <= '0;
			chan_q <= '0;
		end
		else
		begin
			valid_q <= issue;
			if (issue)
			begin
				sop_q <= hwdata[CMD_SOP_BIT];
				eop_q <= hwdata[CMD_EOP_BIT];
				// The empty count is forced to zero on all but the final word.
				emp_q <= hwdata[CMD_EOP_BIT] ? hwdata[CMD_EMPTY_LSB +: EMP_W] : '0;
				chan_q <= hwdata[CMD_CHAN_LSB +: CH_W];
			end
		end
	end

	assign lnk.data_valid = valid_q;
	assign lnk.data = word_q[DATA_W-1:0];
	assign lnk.pkt_start = valid_q && sop_q;
	assign lnk.pkt_end = valid_q && eop_q;
	assign lnk.empty_syms = emp_q;
	assign lnk.data_chan = chan_q;

	// ------------------------------------------------------------------
	// Result capture
	// ------------------------------------------------------------------
	logic res_q;
	logic bad_q;
	logic [CRC_W-1:0] sum_q;
	logic [CH_W-1:0] rchan_q;

	// A new event wins over a write-one clear in the same cycle.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			res_q <= lnk.crc_valid || (res_q && !(wr_stat && hwdata[ST_RES_BIT]));
			refused_q <= (wr_cmd && !lnk.chan_init_done)
				|| (refused_q && !(wr_stat && hwdata[ST_REFUSED_BIT]));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bad_q <= 1'b0;
			sum_q <= '0;
			rchan_q <= '0;
		end
		else if (lnk.crc_valid)
		begin
			bad_q <= lnk.crc_bad;
			sum_q <= lnk.checksum;
			rchan_q <= lnk.crc_chan;
		end
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always_comb
	begin
		hrdata = RDATA_ZERO;
		case (addr_q)
			OFS_WORD: hrdata = word_q;
			OFS_STAT:
			begin
				hrdata[ST_INIT_BIT] = lnk.chan_init_done;
				hrdata[ST_RES_BIT] = res_q;
				hrdata[ST_BAD_BIT] = bad_q;
				hrdata[ST_REFUSED_BIT] = refused_q;
			end
			OFS_SUM: hrdata[CRC_W-1:0] = sum_q;
			OFS_RCHAN: hrdata[CH_W-1:0] = rchan_q;
			default: hrdata = RDATA_ZERO;
		endcase
	end

endmodule

`default_nettype wire

//--- hdl/crcp_if.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Streaming link between the packet source and the CRC engine
// ----------------------------------------------------------------------
interface crcp_if #(
	parameter int DATA_W = 32,
	parameter int EMP_W = 2,
	parameter int CRC_W = 32,
	parameter int CH_W = 2
);
	logic [DATA_W-1:0] data;
	logic data_valid;
	logic pkt_start;
	logic pkt_end;
	logic [EMP_W-1:0] empty_syms;
	logic [CH_W-1:0] data_chan;
	logic chan_init_done;
	logic [CRC_W-1:0] checksum;
	logic crc_bad;
	logic crc_valid;
	logic [CH_W-1:0] crc_chan;

	modport dev (
		input data, data_valid, pkt_start, pkt_end, empty_syms, data_chan,
		output chan_init_done, checksum, crc_bad, crc_valid, crc_chan
	);

	modport src (
		output data, data_valid, pkt_start, pkt_end, empty_syms, data_chan,
		input chan_init_done, checksum, crc_bad, crc_valid, crc_chan
	);
endinterface

`default_nettype wire

//--- hdl/crcp_pkg.sv
package crcp_pkg;

	// ------------------------------------------------------------------
	// Engine defaults
	// ------------------------------------------------------------------
	localparam int DATA_W_DEF = 32;
	localparam int SYMS_DEF = 4;
	localparam int CRC_W_DEF = 32;
	localparam logic [31:0] POLY_DEF = 32'h04C11DB7;
	localparam logic [31:0] INIT_DEF = 32'hFFFFFFFF;
	localparam int CHANNELS_DEF = 4;
	localparam int DATA_W_MIN = 1;
	localparam int DATA_W_MAX = 256;

	// ------------------------------------------------------------------
	// Controller register map (byte addresses, one word each)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_WORD = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_SUM = 8'h0C;
	localparam logic [7:0] OFS_RCHAN = 8'h10;

	// Command word fields.
	localparam int CMD_SOP_BIT = 0;
	localparam int CMD_EOP_BIT = 1;
	localparam int CMD_EMPTY_LSB = 8;
	localparam int CMD_EMPTY_W = 8;
	localparam int CMD_CHAN_LSB = 16;
	localparam int CMD_CHAN_W = 8;

	// Status word fields.
	localparam int ST_INIT_BIT = 0;
	localparam int ST_RES_BIT = 1;
	localparam int ST_BAD_BIT = 2;
	localparam int ST_REFUSED_BIT = 3;

	// AHB-Lite encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [31:0] RDATA_ZERO = 32'h00000000;

endpackage
